// ---- dss_pkg.sv ----
package dss_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int          NSETS   = 3;
    localparam int          NPARAM  = 4;
    localparam int          PARAM_W = 16;
    localparam int          SET_W   = 2;
    localparam logic [1:0]  SET_BAD = 2'h3;
    localparam logic [1:0]  SET_RST = 2'h0;
    // Command parameters 0 to 2 frozen while running
    localparam logic [3:0]  CMD_RUN_LOCK = 4'h7;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ        = 10_000_000;
    localparam int DRV_SWITCH_MS = 50;
    localparam int DRV_SWITCH_CYC = DRV_SWITCH_MS * (CLK_HZ / 1000);
    localparam int TMR_W         = 20;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CMD_SRC   = 8'h00;
    localparam logic [7:0] A_CMD_DST   = 8'h04;
    localparam logic [7:0] A_CMD_START = 8'h08;
    localparam logic [7:0] A_DRV_SRC   = 8'h0C;
    localparam logic [7:0] A_DRV_DST   = 8'h10;
    localparam logic [7:0] A_DRV_START = 8'h14;
    localparam logic [7:0] A_STATUS    = 8'h18;
    localparam logic [7:0] A_SEL_A     = 8'h1C;
    localparam logic [7:0] A_SEL_B     = 8'h20;
    // Parameter windows: addr[7:6] region, [5:4] set, [3:2] param
    localparam logic [1:0] RG_CMD_MEM  = 2'h1;
    localparam logic [1:0] RG_DRV_MEM  = 2'h2;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SEL_CMD_BIT    = 15;
    localparam int SEL_DRV_B0     = 4;
    localparam int SEL_DRV_B1     = 5;
    localparam int ST_CMD_LSB     = 0;
    localparam int ST_DRV_SEL_LSB = 8;
    localparam int ST_DRV_ACT_LSB = 16;
    localparam int ST_CMD_BUSY    = 24;
    localparam int ST_DRV_BUSY    = 25;
    localparam int ST_SWITCHING   = 26;

    // ------------------------------------------------------------------
    // Copy engine states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CP_IDLE = 3'h1,
        CP_RUN  = 3'h2,
        CP_DONE = 3'h4
    } dss_cp_state_t;

endpackage : dss_pkg

// ---- dss_copy_if.sv ----
`timescale 1ns/1ps
interface dss_copy_if;
    logic       start;
    logic [1:0] src;
    logic [1:0] dst;
    logic [1:0] idx;
    logic       we;
    logic       done;
    logic       busy;

    modport engine (input start, src, dst, output idx, we, done, busy);
    modport host   (output start, src, dst, input idx, we, done, busy);
endinterface : dss_copy_if

// ---- dss_copy_engine.sv ----
`timescale 1ns/1ps
module dss_copy_engine
    import dss_pkg::*;
(
    // Clock and reset
    input wire logic   clk,
    input wire logic   rst,
    // Copy request and memory strobe
    dss_copy_if.engine cp
);

    typedef struct packed {
        dss_cp_state_t    state;
        logic [SET_W-1:0] idx;
    } dss_eng_t;

    dss_eng_t q;
    dss_eng_t d;
    logic     bad;

    assign bad     = (cp.src == SET_BAD) || (cp.dst == SET_BAD);
    assign cp.idx  = q.idx;
    assign cp.busy = (q.state != CP_IDLE);

    // ------------------------------------------------------------------
    // Walk every parameter once
    // ------------------------------------------------------------------
    always_comb begin
        d       = q;
        cp.we   = 1'b0;
        cp.done = 1'b0;
        case (q.state)
            CP_IDLE: begin
                if (cp.start) begin
                    if (bad) begin
                        d.state = CP_DONE;
                    end else begin
                        d.state = CP_RUN;
                        d.idx   = '0;
                    end
                end
            end
            CP_RUN: begin
                cp.we = 1'b1;
                if (q.idx == SET_W'(NPARAM - 1)) begin
                    d.state = CP_DONE;
                end else begin
                    d.idx = q.idx + 2'h1;
                end
            end
            CP_DONE: begin
                cp.done = 1'b1;
                d.state = CP_IDLE;
            end
            default: begin
                d.state = CP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '{state: CP_IDLE, idx: '0};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_walk;
        cp.we [*4] ##1 (cp.done && !cp.we);
    endsequence

    a_copy_walk: assert property (
        (q.state == CP_IDLE && cp.start && !bad) |=> s_walk)
        else $error("copy did not walk four params then finish");

    a_bad_index: assert property (
        (q.state == CP_IDLE && cp.start && bad) |=> (cp.done && !cp.we))
        else $error("bad copy index not finished at once");

endmodule : dss_copy_engine

// ---- dss_data_set_select.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Switchover applies new values; three locked parameters hold while running.
// - Writing 1 starts command copy; hardware clears it when finished.
// - Command set picked from two inputs; active number readable.
// - Command set changes in both Ready and Run.
// - Status bit 15 pair decodes to command set 0, 1 or 2.
// - Writing 1 starts drive copy; hardware clears it when finished.
// - Drive set changes only in Ready, after about 50 ms.
// - Drive set decoded from bits 5 and 4; selected and active shown.
// - Each parameter holds three values; active set's value is used.
// - Exactly three command sets and three drive sets, numbered 0 to 2.
module dss_data_set_select
    import dss_pkg::*;
#(
    parameter int DRV_SWITCH_CYCLES = DRV_SWITCH_CYC
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // Avalon-MM slave
    input  wire logic [7:0]                address,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [31:0]               writedata,
    output      logic [31:0]               readdata,
    output      logic                      waitrequest,
    // Selection pins, asynchronous
    input  wire logic                      command_select_bit0_src,
    input  wire logic                      command_select_bit1_src,
    input  wire logic                      drive_select_bit0_src,
    input  wire logic                      drive_select_bit1_src,
    // Drive state, same clock
    input  wire logic                      drive_ready,
    input  wire logic                      drive_run,
    // Applied parameters and set status
    output      logic [NPARAM*PARAM_W-1:0] cmd_param_out,
    output      logic [NPARAM*PARAM_W-1:0] drv_param_out,
    output      logic [SET_W-1:0]          active_command_set,
    output      logic [SET_W-1:0]          active_drive_set,
    output      logic                      drive_switching
);

    typedef logic [NSETS-1:0][NPARAM-1:0][PARAM_W-1:0] dss_mem_t;
    typedef logic [NPARAM-1:0][PARAM_W-1:0]             dss_vec_t;

    typedef struct packed {
        logic [3:0]       sync1;
        logic [3:0]       sync2;
        logic             ack;
        logic [31:0]      rdata;
        logic [SET_W-1:0] cmd_src;
        logic [SET_W-1:0] cmd_dst;
        logic [SET_W-1:0] drv_src;
        logic [SET_W-1:0] drv_dst;
        logic             cmd_start;
        logic             drv_start;
        logic [SET_W-1:0] cmd_act;
        logic [SET_W-1:0] drv_act;
        logic [SET_W-1:0] drv_tgt;
        logic [TMR_W-1:0] tmr;
        dss_mem_t         cmd_mem;
        dss_mem_t         drv_mem;
        dss_vec_t         cmd_out;
        dss_vec_t         drv_out;
    } dss_state_t;

    dss_state_t       q;
    dss_state_t       d;
    dss_copy_if       cmd_cp ();
    dss_copy_if       drv_cp ();
    logic             req;
    logic             stall;
    logic             mem_ok;
    logic             pend;
    logic [SET_W-1:0] cmd_sel;
    logic [SET_W-1:0] drv_sel;
    logic [31:0]      rd;

    // ------------------------------------------------------------------
    // Copy engines
    // ------------------------------------------------------------------
    assign cmd_cp.start = q.cmd_start;
    assign cmd_cp.src   = q.cmd_src;
    assign cmd_cp.dst   = q.cmd_dst;
    assign drv_cp.start = q.drv_start;
    assign drv_cp.src   = q.drv_src;
    assign drv_cp.dst   = q.drv_dst;

    dss_copy_engine u_cmd_copy (.clk(clk), .rst(rst), .cp(cmd_cp.engine));
    dss_copy_engine u_drv_copy (.clk(clk), .rst(rst), .cp(drv_cp.engine));

    // ------------------------------------------------------------------
    // Decode and bus handshake
    // ------------------------------------------------------------------
    // command and drive decode
    assign cmd_sel = q.sync2[1] ? 2'h2 : (q.sync2[0] ? 2'h1 : 2'h0);
    assign drv_sel = q.sync2[3] ? 2'h2 : (q.sync2[2] ? 2'h1 : 2'h0);

    assign req    = read || write;
    assign mem_ok = (address[5:4] != SET_BAD);
    // Parameter writes wait out a running copy of the same kind
    assign stall  = write && mem_ok &&
                    ((address[7:6] == RG_CMD_MEM && cmd_cp.busy) ||
                     (address[7:6] == RG_DRV_MEM && drv_cp.busy));
    assign waitrequest = req && !q.ack;
    assign pend        = (drv_sel != q.drv_act);

    always_comb begin
        rd = '0;
        if (address == A_CMD_SRC) begin
            rd[SET_W-1:0] = q.cmd_src;
        end else if (address == A_CMD_DST) begin
            rd[SET_W-1:0] = q.cmd_dst;
        end else if (address == A_CMD_START) begin
            rd[0] = q.cmd_start;
        end else if (address == A_DRV_SRC) begin
            rd[SET_W-1:0] = q.drv_src;
        end else if (address == A_DRV_DST) begin
            rd[SET_W-1:0] = q.drv_dst;
        end else if (address == A_DRV_START) begin
            rd[0] = q.drv_start;
        end else if (address == A_STATUS) begin
            rd[ST_CMD_LSB +: SET_W]     = q.cmd_act;
            rd[ST_DRV_SEL_LSB +: SET_W] = drv_sel;
            rd[ST_DRV_ACT_LSB +: SET_W] = q.drv_act;
            rd[ST_CMD_BUSY]             = cmd_cp.busy;
            rd[ST_DRV_BUSY]             = drv_cp.busy;
            rd[ST_SWITCHING]            = pend;
        end else if (address == A_SEL_A) begin
            rd[SEL_CMD_BIT] = q.sync2[0];
        end else if (address == A_SEL_B) begin
            rd[SEL_CMD_BIT] = q.sync2[1];
            rd[SEL_DRV_B0]  = q.sync2[2];
            rd[SEL_DRV_B1]  = q.sync2[3];
        end else if (address[7:6] == RG_CMD_MEM && mem_ok) begin
            rd[PARAM_W-1:0] = q.cmd_mem[address[5:4]][address[3:2]];
        end else if (address[7:6] == RG_DRV_MEM && mem_ok) begin
            rd[PARAM_W-1:0] = q.drv_mem[address[5:4]][address[3:2]];
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d       = q;
        d.sync1 = {drive_select_bit1_src, drive_select_bit0_src,
                   command_select_bit1_src, command_select_bit0_src};
        d.sync2 = q.sync1;
        d.ack   = req && !q.ack && !stall;
        if (req && !q.ack) begin
            d.rdata = rd;
        end
        if (cmd_cp.done) begin
            d.cmd_start = 1'b0;
        end
        if (drv_cp.done) begin
            d.drv_start = 1'b0;
        end
        if (write && q.ack) begin
            if (address == A_CMD_SRC && !cmd_cp.busy) begin
                d.cmd_src = writedata[SET_W-1:0];
            end else if (address == A_CMD_DST && !cmd_cp.busy) begin
                d.cmd_dst = writedata[SET_W-1:0];
            end else if (address == A_CMD_START && writedata[0]) begin
                d.cmd_start = 1'b1;
            end else if (address == A_DRV_SRC && !drv_cp.busy) begin
                d.drv_src = writedata[SET_W-1:0];
            end else if (address == A_DRV_DST && !drv_cp.busy) begin
                d.drv_dst = writedata[SET_W-1:0];
            end else if (address == A_DRV_START && writedata[0]) begin
                d.drv_start = 1'b1;
            end else if (address[7:6] == RG_CMD_MEM && mem_ok) begin
                d.cmd_mem[address[5:4]][address[3:2]] =
                    writedata[PARAM_W-1:0];
            end else if (address[7:6] == RG_DRV_MEM && mem_ok) begin
                d.drv_mem[address[5:4]][address[3:2]] =
                    writedata[PARAM_W-1:0];
            end
        end
        if (cmd_cp.we) begin
            d.cmd_mem[q.cmd_dst][cmd_cp.idx] = q.cmd_mem[q.cmd_src][cmd_cp.idx];
        end
        if (drv_cp.we) begin
            d.drv_mem[q.drv_dst][drv_cp.idx] = q.drv_mem[q.drv_src][drv_cp.idx];
        end
        if (drive_ready || drive_run) begin
            d.cmd_act = cmd_sel;
        end
        d.tmr     = '0;
        d.drv_tgt = drv_sel;
        if (drive_ready && !drive_run && pend && drv_sel == q.drv_tgt) begin
            if (q.tmr == TMR_W'(DRV_SWITCH_CYCLES - 1)) begin
                d.drv_act = drv_sel;
            end else begin
                d.tmr = q.tmr + 1'b1;
            end
        end
        for (int p = 0; p < NPARAM; p++) begin
            d.drv_out[p] = q.drv_mem[q.drv_act][p];
            if (!(drive_run && CMD_RUN_LOCK[p])) begin
                d.cmd_out[p] = q.cmd_mem[q.cmd_act][p];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q         <= '0;
            q.cmd_act <= SET_RST;
            q.drv_act <= SET_RST;
            q.drv_tgt <= SET_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign readdata           = q.rdata;
    assign cmd_param_out      = q.cmd_out;
    assign drv_param_out      = q.drv_out;
    assign active_command_set = q.cmd_act;
    assign active_drive_set   = q.drv_act;
    assign drive_switching    = pend;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_cmd_follow: assert property (
        (drive_ready || drive_run) |=> (q.cmd_act == $past(cmd_sel)))
        else $error("active command set not decoded from selection");

    a_cmd_hold: assert property (
        !(drive_ready || drive_run) |=> $stable(q.cmd_act))
        else $error("command set changed outside ready and run");

    a_drv_no_run: assert property (
        (drive_run || !drive_ready) |=> $stable(q.drv_act))
        else $error("drive set changed outside ready");

    a_drv_delay: assert property (
        $changed(q.drv_act) |->
            $past(q.tmr) == TMR_W'(DRV_SWITCH_CYCLES - 1))
        else $error("drive set switched before full delay");

    a_drv_decode: assert property (
        (q.sync2[3] |-> drv_sel == 2'h2) and
        ((q.sync2[3:2] == 2'h1) |-> drv_sel == 2'h1))
        else $error("drive selection decode wrong");

    a_lock_run: assert property (
        drive_run |=> $stable(q.cmd_out[0]))
        else $error("locked parameter updated while running");

    a_param_apply: assert property (
        1'b1 |=> q.drv_out[NPARAM-1] ==
                 $past(q.drv_mem[q.drv_act][NPARAM-1]))
        else $error("drive parameter not taken from active set");

    a_set_range: assert property (
        q.cmd_act != SET_BAD && q.drv_act != SET_BAD)
        else $error("active set number out of range");

    a_status_read: assert property (
        (read && !q.ack && address == A_STATUS) |=>
            readdata[ST_CMD_LSB +: SET_W] == $past(q.cmd_act))
        else $error("status read lost active command set");

endmodule : dss_data_set_select

// ---- dss_sel_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Selection sources and drive state seen by the block
// ----------------------------------------------------------------------
module dss_sel_model (
    // Clock
    input  wire logic       clk,
    // Requested codes and state from the bench
    input  wire logic [1:0] cmd_code,
    input  wire logic [1:0] drv_code,
    input  wire logic       rdy_req,
    input  wire logic       run_req,
    // Pins toward the block
    output      logic       command_select_bit0_src,
    output      logic       command_select_bit1_src,
    output      logic       drive_select_bit0_src,
    output      logic       drive_select_bit1_src,
    output      logic       drive_ready,
    output      logic       drive_run
);
    // One edge late, like a real source; unknown only while held in reset
    always @(posedge clk) begin
        command_select_bit0_src <= cmd_code[0];
        command_select_bit1_src <= cmd_code[1];
        drive_select_bit0_src   <= drv_code[0];
        drive_select_bit1_src   <= drv_code[1];
        drive_ready             <= rdy_req;
        drive_run               <= run_req;
    end
endmodule : dss_sel_model

// ---- test_data_set_select.sv ----
`timescale 1ns/1ps
module test_data_set_select
    import dss_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int SWC = 8;
    typedef struct packed {
        logic [1:0] cb;
        logic [1:0] db;
        logic       rdy;
        logic       run;
        logic [1:0] ec;
        logic [1:0] ed;
    } dss_row_t;
    logic               clk, rst, read, write, waitrequest;
    logic [7:0]         address;
    logic [31:0]        writedata, readdata, q;
    logic               cb0, cb1, db0, db1, d_rdy, d_run, drive_switching;
    logic [1:0]         cmd_code, drv_code, active_command_set;
    logic [1:0]         active_drive_set, prev_drv;
    logic               rdy_req, run_req;
    logic [63:0]        cmd_param_out, drv_param_out;
    logic [15:0]        mem [2][3][4];
    logic [15:0]        cur [4];
    logic [31:0]        st;
    int                 error_cnt, compares;
    dss_row_t           r;
    dss_row_t           rows [7] = '{
        '{2'h0, 2'h0, 1'b1, 1'b0, 2'h0, 2'h0},
        '{2'h1, 2'h1, 1'b1, 1'b0, 2'h1, 2'h1},
        '{2'h2, 2'h2, 1'b1, 1'b0, 2'h2, 2'h2},
        '{2'h3, 2'h3, 1'b1, 1'b0, 2'h2, 2'h2},
        '{2'h1, 2'h0, 1'b0, 1'b1, 2'h1, 2'h2},
        '{2'h0, 2'h1, 1'b0, 1'b0, 2'h1, 2'h2},
        '{2'h0, 2'h1, 1'b1, 1'b0, 2'h0, 2'h1}};

    dss_data_set_select #(.DRV_SWITCH_CYCLES(SWC)) i_dss_data_set_select (
        .clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .command_select_bit0_src(cb0),
        .command_select_bit1_src(cb1), .drive_select_bit0_src(db0),
        .drive_select_bit1_src(db1), .drive_ready(d_rdy),
        .drive_run(d_run), .cmd_param_out(cmd_param_out),
        .drv_param_out(drv_param_out),
        .active_command_set(active_command_set),
        .active_drive_set(active_drive_set),
        .drive_switching(drive_switching));

    dss_sel_model i_dss_sel_model (
        .clk(clk), .cmd_code(cmd_code), .drv_code(drv_code),
        .rdy_req(rdy_req), .run_req(run_req),
        .command_select_bit0_src(cb0), .command_select_bit1_src(cb1),
        .drive_select_bit0_src(db0), .drive_select_bit1_src(db1),
        .drive_ready(d_rdy), .drive_run(d_run));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    always #50 clk = ~clk;

    task automatic stop_test;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    // Held until the edge where waitrequest is low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        int n;
        n = 0;
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        if (n >= 100) error_cnt++;
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask : bus

    function automatic logic [1:0] dec2(input logic [1:0] c);
        return c[1] ? 2'h2 : (c[0] ? 2'h1 : 2'h0);
    endfunction : dec2

    // Copy then compare target window with the expected sets
    task automatic do_copy(input int k, input int s, input int t);
        logic [7:0] b;
        int         n;
        b = k ? A_DRV_SRC : A_CMD_SRC;
        n = 0;
        bus(1'b1, b, 32'(s), q);
        bus(1'b1, b + 8'h04, 32'(t), q);
        bus(1'b1, b + 8'h08, 32'h0000_0001, q);
        bus(1'b0, A_STATUS, 32'h0, q);
        chk(32'(q[ST_CMD_BUSY + k]), 32'h0000_0001);
        do begin
            bus(1'b0, b + 8'h08, 32'h0000_0000, q);
            n++;
        end while (q[0] === 1'b1 && n < 50);
        chk(q, 32'h0000_0000);
        for (int p = 0; p < 4; p++) begin
            if (s < 3) mem[k][t][p] = mem[k][s][p];
            bus(1'b0, {2'(k + 1), 2'(t), 2'(p), 2'b00}, 32'h0, q);
            chk(q, {16'h0000, mem[k][t][p]});
        end
    endtask : do_copy

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (6000) @(posedge clk);
        error_cnt++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0; rst = 1'b1; read = 1'b0; write = 1'b0;
        address = 8'h00; writedata = 32'h0000_0000;
        cmd_code = 2'h0; drv_code = 2'h0; rdy_req = 1'b1; run_req = 1'b0;
        error_cnt = 0; compares = 0; prev_drv = 2'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 2; k++)
            for (int s = 0; s < 3; s++)
                for (int p = 0; p < 4; p++) begin
                    mem[k][s][p] = 16'(32'h1000 * (k + 1) + 32'h10 * s + p);
                    bus(1'b1, {2'(k + 1), 2'(s), 2'(p), 2'b00},
                        {16'h0000, mem[k][s][p]}, q);
                end
        for (int p = 0; p < 4; p++) cur[p] = mem[0][0][p];
        do_copy(0, 2, 0);
        do_copy(1, 1, 2);
        do_copy(0, 3, 1);
        do_copy(1, 3, 1);
        foreach (rows[i]) begin
            r = rows[i];
            cmd_code <= r.cb; drv_code <= r.db;
            rdy_req <= r.rdy; run_req <= r.run;
            repeat (6) @(posedge clk);
            if (r.ed != prev_drv) begin
                chk(32'(active_drive_set), 32'(prev_drv));
                chk(32'(drive_switching), 32'h0000_0001);
            end
            repeat (20) @(posedge clk);
            prev_drv = r.ed;
            chk(32'(active_command_set), 32'(r.ec));
            chk(32'(active_drive_set), 32'(r.ed));
            chk(32'(drive_switching), 32'(dec2(r.db) != r.ed));
            st = 32'h0000_0000;
            st[1:0] = r.ec;
            st[9:8] = dec2(r.db);
            st[17:16] = r.ed;
            st[26] = (dec2(r.db) != r.ed);
            bus(1'b0, A_STATUS, 32'h0, q);
            chk(q, st);
            bus(1'b0, A_SEL_A, 32'h0, q);
            chk(q, {16'h0000, r.cb[0], 15'h0000});
            bus(1'b0, A_SEL_B, 32'h0, q);
            chk(q, {16'h0000, r.cb[1], 9'h000, r.db, 4'h0});
            for (int p = 0; p < 4; p++) begin
                // Locked params hold only while running
                if (!(r.run && p < 3)) cur[p] = mem[0][r.ec][p];
                chk({16'h0, cmd_param_out[16*p +: 16]}, {16'h0, cur[p]});
                chk({16'h0, drv_param_out[16*p +: 16]},
                    {16'h0, mem[1][r.ed][p]});
            end
        end
        // Unmapped places read zero, writes dropped
        bus(1'b0, 8'h24, 32'h0, q);
        chk(q, 32'h0000_0000);
        bus(1'b1, 8'h70, 32'h0000_5a5a, q);
        bus(1'b0, 8'h70, 32'h0, q);
        chk(q, 32'h0000_0000);
        // Reset again with the drive in Ready, not running
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(active_command_set), 32'h0000_0000);
        chk(32'(active_drive_set), 32'h0000_0000);
        chk(cmd_param_out[31:0], 32'h0000_0000);
        chk(readdata, 32'h0000_0000);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, A_CMD_SRC, 32'h0, q);
        chk(q, 32'h0000_0000);
        stop_test();
    end
endmodule : test_data_set_select
